/* logic/cas_pkg.sv */
package cas_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses) and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CAS_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  CAS_OFS_MONO   = 8'h04;
  localparam logic [7:0]  CAS_OFS_STATUS = 8'h08;
  localparam logic [7:0]  CAS_CTRL_RST   = 8'h5F;
  localparam logic [15:0] CAS_MONO_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CAS_CLK_NS  = 10;
  localparam int CAS_TMF_NS  = 21000;  // internal monoflop time
  localparam logic [15:0] CAS_MF_CYC = 16'(CAS_TMF_NS / CAS_CLK_NS);
  localparam logic [2:0]  CAS_RISE_SAT = 3'h7;
  localparam logic [2:0]  CAS_BIN_SKIP = 3'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CAS_GRAY = 4'b0001,
    CAS_BIN  = 4'b0010,
    CAS_PASS = 4'b0100,
    CAS_SSI  = 4'b1000
  } cas_mode_e;

  typedef enum logic [2:0] {
    CAS_PH_IDLE  = 3'b001,
    CAS_PH_SYNC  = 3'b010,
    CAS_PH_SHIFT = 3'b100
  } cas_phase_e;

  // control register fields, bit 7 downward
  typedef struct packed {
    logic tp_enable;
    logic mode_sel;
    logic test_enable;
    logic error_phase_sel;
    logic all_invert_n;
    logic direction_invert_n;
    logic sync_mode_sel1;
    logic sync_mode_sel0;
  } cas_ctrl_s;

  typedef struct packed {
    cas_ctrl_s   ctrl;
    logic [15:0] mono;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    cas_phase_e  phase;
    logic [15:0] mono_cnt;
    logic        sclk_prev;
    logic [5:0]  sr;
    logic [1:0]  low;
    logic [2:0]  rise_cnt;
    logic [4:0]  word;
    logic [4:0]  test_sr;
    logic [4:0]  sel_sr;
    logic        dout;
    logic        fault_n;
    logic        fault_oe;
    logic        iddq;
  } cas_state_s;

endpackage

/* logic/cas_sync3.sv */
`timescale 1ns/1ns
// three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module cas_sync3 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // stage 1 feeds stage 2 only; the idle level of the link is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
      level  <= '1;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          level[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

/* logic/cas_shifter.sv */
`timescale 1ns/1ns
// Summary of operation
// - two select bits pick gray, binary, passthrough-sync or ssi-sync mode
// - gray mode with error select appends an active-low led error bit
// - binary mode ignores the error select and never sends an error bit
// - unsynced: capture five tracks on first fall after idle, send on rises
// - unsynced acts as 5 or 6 bit shifter, in on falls, out on rises
// - binary mode converts gray to binary, refuses input around rises one and two
// - direction invert flips the msb, all invert flips every track bit
// - synced modes use lsb as sync bit, binary word corrected by one
// - error/phase select high means sync track trails, low means it leads
// - sync against predecessor msb during first low and first high period
// - passthrough-sync: synced result goes straight to the serial output for the next chip
// - synced modes shift four bits, the sync bit is not sent
// - ssi mode holds output high until the first rise, then sends msb
// - test enable with mode high is digital test, mode low analog test
// - analog test: five-bit select register picks tracks, xored onto output
// - analog test with direction invert low enables quiescent-current test
// - digital test: input runs through test register, captured instead of tracks
// - digital test in binary mode takes no stimuli into the test register
// - threshold test xors all digital inputs onto a push-pull fault output
// - idle monoflop period set externally, internal default when unset
// - chain sync must finish by the second falling clock edge
// - fault output and error bit assert when led control leaves range
module cas_shifter
  import cas_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sclk_pin,
  input  wire logic        chain_data_in,
  input  wire logic [4:0]  track_in,
  input  wire logic        led_range_err,
  output logic             chain_data_out,
  output logic             fault_out_n,
  output logic             fault_out_oe,
  output logic             iddq_test
);
  import cas_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic cas_mode_e mode_of(input cas_ctrl_s c);
    unique case ({c.sync_mode_sel1, c.sync_mode_sel0})
      2'b11:   mode_of = CAS_GRAY;
      2'b10:   mode_of = CAS_BIN;
      2'b01:   mode_of = CAS_PASS;
      default: mode_of = CAS_SSI;
    endcase
  endfunction

  function automatic logic [4:0] g2b(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // trailing sync track: predecessor msb up, own lsb still low -> step up;
  // leading track: predecessor msb low, own lsb already high -> step down
  function automatic logic [3:0] correct(input logic [4:0] b, input logic pred,
                                         input logic trail);
    logic [3:0] v;
    v = b[4:1];
    if (trail && pred && !b[0]) begin
      v = v + 4'h1;
    end else if (!trail && !pred && b[0]) begin
      v = v - 4'h1;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic       sclk_s;
  logic       din_s;
  cas_state_s q;
  cas_state_s d;

  cas_sync3 #(.WIDTH(2)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     ({sclk_pin, chain_data_in}),
    .level   ({sclk_s, din_s})
  );

  // ---------------------------------------------------------------
  // decoded conditions
  // ---------------------------------------------------------------
  cas_mode_e   mode;
  logic        rise;
  logic        fall;
  logic        idle;
  logic        dtest;
  logic        atest;
  logic        unsync;
  logic [15:0] period;
  logic [4:0]  tracks;
  logic [4:0]  bin;
  logic [3:0]  corr;
  logic        pin_xor;

  assign mode    = mode_of(q.ctrl);
  assign rise    = sclk_s & ~q.sclk_prev;
  assign fall    = ~sclk_s & q.sclk_prev;
  assign period  = (q.mono == 16'h0000) ? CAS_MF_CYC : q.mono;
  assign idle    = (q.mono_cnt >= period);  // a shortened period expires at once
  assign dtest   = q.ctrl.test_enable & q.ctrl.mode_sel;
  assign atest   = q.ctrl.test_enable & ~q.ctrl.mode_sel;
  assign unsync  = (mode == CAS_GRAY) || (mode == CAS_BIN);
  // invert before conversion; both low leaves the msb as read
  assign tracks  = (dtest ? q.test_sr : track_in)
                   ^ {5{~q.ctrl.all_invert_n}}
                   ^ {~q.ctrl.direction_invert_n, 4'h0};
  assign bin     = g2b(tracks);
  assign corr    = correct(q.word, din_s, q.ctrl.error_phase_sel);
  assign pin_xor = ^{q.ctrl.sync_mode_sel0, q.ctrl.sync_mode_sel1, din_s, sclk_s,
                     q.ctrl.direction_invert_n, q.ctrl.all_invert_n,
                     q.ctrl.error_phase_sel};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       sin;
    logic [5:0] shifted;
    d = q;
    sin = din_s;
    shifted = {q.sr[4:0], 1'b0};
    d.sclk_prev = sclk_s;

    // bus: write lands in its data phase, then the read sees it
    if (q.wr_pend) begin
      unique case (q.wr_addr)
        CAS_OFS_CTRL: d.ctrl = cas_ctrl_s'(hwdata[7:0]);
        CAS_OFS_MONO: d.mono = hwdata[15:0];
        default: ;
      endcase
    end
    d.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      d.wr_pend = hwrite;
      d.wr_addr = haddr[7:0];
      if (!hwrite) begin
        unique case (haddr[7:0])
          CAS_OFS_CTRL:   d.hrdata = {24'h000000, d.ctrl};
          CAS_OFS_MONO:   d.hrdata = {16'h0000, d.mono};
          CAS_OFS_STATUS: d.hrdata = {q.phase, q.rise_cnt, q.low, q.sr, q.word,
                                      q.test_sr, q.sel_sr, q.dout, idle, ~q.fault_n};
          default:        d.hrdata = 32'h00000000;
        endcase
      end
    end

    // idle monoflop, retriggered by either clock edge
    if (rise || fall) begin
      d.mono_cnt = 16'h0000;
    end else if (!idle) begin
      d.mono_cnt = q.mono_cnt + 16'h0001;
    end

    if (rise && q.rise_cnt != CAS_RISE_SAT) begin
      d.rise_cnt = q.rise_cnt + 3'h1;
    end

    // test register in front of the chain input
    if (dtest && fall && mode != CAS_BIN) begin
      d.test_sr = {q.test_sr[3:0], din_s};
    end
    if (dtest) begin
      sin = q.test_sr[4];
    end
    if (mode == CAS_BIN && q.rise_cnt <= CAS_BIN_SKIP) begin
      sin = 1'b0;
    end

    // serial engine
    unique case (q.phase)
      CAS_PH_IDLE: begin
        if (fall && idle) begin
          d.rise_cnt = 3'h0;
          if (unsync) begin
            d.phase = CAS_PH_SHIFT;
            if (mode == CAS_GRAY && q.ctrl.error_phase_sel) begin
              d.sr  = {tracks, ~led_range_err};
              d.low = 2'h0;
            end else begin
              d.sr  = {(mode == CAS_BIN) ? bin : tracks, 1'b0};
              d.low = 2'h1;
            end
          end else begin
            d.phase = CAS_PH_SYNC;
            d.word  = bin;
            d.low   = 2'h2;
            d.dout  = 1'b1;
          end
        end
      end
      CAS_PH_SYNC: begin
        // word tracks the predecessor msb until the second fall
        if (mode == CAS_PASS || rise || q.rise_cnt != 3'h0) begin
          d.dout = corr[3];
        end else begin
          d.dout = 1'b1;
        end
        if (rise) begin
          d.sr = {corr, 2'h0};
        end
        if (fall) begin
          d.phase = CAS_PH_SHIFT;
          d.sr    = {corr[2:0], sin, 2'h0};
        end
      end
      CAS_PH_SHIFT: begin
        if (rise) begin
          d.dout = q.sr[5];
        end
        if (fall) begin
          for (int i = 0; i < 6; i++) begin
            d.sr[i] = (i == int'(q.low)) ? sin :
                      (i < int'(q.low)) ? 1'b0 : shifted[i];
          end
        end
      end
      default: d.phase = CAS_PH_IDLE;
    endcase
    if (idle && q.phase != CAS_PH_IDLE) begin
      d.phase = CAS_PH_IDLE;
      d.dout  = 1'b1;
    end

    // analog test: select register clocked on the low-going clock
    if (atest) begin
      if (fall) begin
        d.sel_sr = {q.sel_sr[3:0], din_s};
      end
      d.dout  = ^(track_in & q.sel_sr);
      d.phase = CAS_PH_IDLE;
    end
    d.iddq = atest & ~q.ctrl.direction_invert_n;

    // fault pin: open drain normally, push-pull in threshold test
    if (dtest && q.ctrl.tp_enable) begin
      d.fault_n  = pin_xor;
      d.fault_oe = 1'b1;
    end else begin
      d.fault_n  = ~led_range_err;
      d.fault_oe = led_range_err;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q          <= '0;
      q.ctrl     <= cas_ctrl_s'(CAS_CTRL_RST);
      q.mono     <= CAS_MONO_RST;
      q.phase    <= CAS_PH_IDLE;
      q.mono_cnt <= CAS_MF_CYC;
      q.sclk_prev <= 1'b1;
      q.dout     <= 1'b1;
      q.fault_n  <= 1'b1;
      q.rise_cnt <= CAS_RISE_SAT;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops; zero-wait, always okay
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign hrdata         = q.hrdata;
  assign chain_data_out = q.dout;
  assign fault_out_n    = q.fault_n;
  assign fault_out_oe   = q.fault_oe;
  assign iddq_test      = q.iddq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence cap_s;
    q.phase == CAS_PH_IDLE && fall && idle && !atest;
  endsequence
  sequence unsync_cap_s;
    cap_s and (unsync && !dtest);
  endsequence

  err_bit_a: assert property ((unsync_cap_s and (mode == CAS_GRAY &&
      q.ctrl.error_phase_sel)) |=> q.low == 2'h0 && q.sr[0] == !$past(led_range_err))
    else $error("error bit not appended");
  bin_no_err_a: assert property ((cap_s and mode == CAS_BIN)
      |=> q.low == 2'h1 && q.sr[0] == 1'b0)
    else $error("binary mode carries an error bit");
  all_invert_a: assert property ((unsync_cap_s and (mode == CAS_GRAY &&
      !q.ctrl.all_invert_n && q.ctrl.direction_invert_n))
      |=> q.sr[5:1] == ~$past(track_in))
    else $error("track inversion wrong");
  bin_refuse_a: assert property (mode == CAS_BIN && q.phase == CAS_PH_SHIFT &&
      fall && q.rise_cnt <= 3'h2 && !idle |=> q.sr[1] == 1'b0)
    else $error("binary mode accepted early input");
  ssi_blank_a: assert property (q.phase == CAS_PH_SYNC && mode == CAS_SSI &&
      q.rise_cnt == 3'h0 |-> chain_data_out)
    else $error("ssi output not held high");
  pass_route_a: assert property (q.phase == CAS_PH_SYNC && mode == CAS_PASS &&
      !idle && !atest |=> chain_data_out == $past(corr[3]))
    else $error("sync result not routed");
  sync_shift_a: assert property (q.phase == CAS_PH_SHIFT && !unsync &&
      fall && !idle && !atest && !dtest |=> q.sr[2] == $past(din_s) && q.sr[1:0] == 2'h0)
    else $error("four bit shift wrong");
  mono_retrig_a: assert property ((rise || fall) |=> q.mono_cnt == 16'h0000
      ##1 (q.mono_cnt == 16'h0001 || rise || fall || $past(rise) || $past(fall)))
    else $error("monoflop not retriggered");
  analog_sel_a: assert property (atest |=>
      chain_data_out == ^($past(track_in) & $past(q.sel_sr)))
    else $error("analog select output wrong");
  tp_xor_a: assert property (dtest && q.ctrl.tp_enable |=>
      fault_out_oe && fault_out_n == $past(pin_xor))
    else $error("threshold xor not driven");
  iddq_a: assert property (atest && !q.ctrl.direction_invert_n |=> iddq_test)
    else $error("quiescent test not enabled");

endmodule

/* bench/cas_ssi_master.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ssi master plus one upstream chained device
// ---------------------------------------------------------------
module cas_ssi_master (
  output logic      sclk_pin,
  output logic      chain_data_in,
  input  wire logic chain_data_out
);
  // link starts high; the clock rests high between bursts
  initial begin
    sclk_pin = 1'b1;
    chain_data_in = 1'b1;
  end

  // one burst of n clocks at 125 ns; up[i] stands across fall i, so the
  // predecessor msb holds over falls 0 and 1; bits[k] is taken late in
  // the high phase after rise k, where the output is settled
  task automatic frame(input int n, input logic [15:0] up, output logic pre,
                       output logic [15:0] bits);
    bits = '0;
    pre = 1'b0;
    chain_data_in <= up[0];
    #20;
    for (int i = 0; i < n; i++) begin
      sclk_pin <= 1'b0;
      #61;
      if (i == 0) pre = chain_data_out;
      #1;
      sclk_pin <= 1'b1;
      chain_data_in <= up[i+1];
      #60;
      bits[i] = chain_data_out;
      #3;
    end
  endtask
endmodule

/* bench/cas_shifter_tb.sv */
`timescale 1ns/1ns
module chained_absolute_encoder_ssi_shifter_tb_top;
  import cas_pkg::*;
  logic        ref_clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [4:0]  track_in;
  logic        led_range_err, sclk, din, dout, fault_n, fault_oe, iddq, pre;
  logic [15:0] bits;
  int          err_count, n_compared;

  // ---------------------------------------------------------------
  // clock, wiring
  // ---------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  assign hready = hreadyout;  // single slave drives the bus ready

  cas_shifter uut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .sclk_pin(sclk), .chain_data_in(din), .track_in(track_in),
    .led_range_err(led_range_err), .chain_data_out(dout), .fault_out_n(fault_n),
    .fault_out_oe(fault_oe), .iddq_test(iddq));
  cas_ssi_master master (.sclk_pin(sclk), .chain_data_in(din), .chain_data_out(dout));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // single ahb-lite word transfer; waits on hready, never on a cycle count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  // idle long enough for the shortened monoflop, then one burst
  task automatic run(input logic [7:0] c, input logic [4:0] t, input logic [15:0] up);
    xfer(1'b1, CAS_OFS_CTRL, 32'(c), rd);
    track_in <= t;
    repeat (40) @(posedge ref_clk);
    master.frame(12, up, pre, bits);
  endtask

  function automatic logic [4:0] g2b(input logic [4:0] g);
    logic [4:0] b;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) b[i] = b[i+1] ^ g[i];
    return b;
  endfunction

  // expected unsynced stream: tracks msb first, error bit, then upstream
  function automatic logic [15:0] exp_uns(input logic [7:0] c, input logic [4:0] trk,
                                          input logic err, input logic [15:0] up);
    logic [4:0]  t;
    logic [15:0] e;
    logic        bin;
    int          j;
    t = trk;
    e = '0;
    bin = (c[1:0] == 2'b10);
    if (!c[2]) t[4] = ~t[4];
    if (!c[3]) t = ~t;
    if (bin) t = g2b(t);
    for (int k = 0; k < 5; k++) e[k] = t[4-k];
    j = 5;
    if (!bin && c[4]) begin
      e[5] = ~err;
      j = 6;
    end
    for (int k = j; k < 12; k++) e[k] = (bin && k - j < 2) ? 1'b0 : up[k-j+1];
    return e;
  endfunction

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // a hung handshake cannot stall the run past this span
  initial begin
    #300000;
    err_count++;
    report_and_stop;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  localparam logic [7:0] UC [8] = '{8'h5F, 8'h5F, 8'h4F, 8'h4B, 8'h47, 8'h43, 8'h5E, 8'h5E};
  localparam logic [4:0] UT [8] = '{5'h16, 5'h0B, 5'h16, 5'h16, 5'h16, 5'h16, 5'h19, 5'h0D};
  localparam logic       UE [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic [7:0] SC [5] = '{8'h5C, 8'h5C, 8'h5D, 8'h4C, 8'h4C};
  localparam logic [4:0] ST [5] = '{5'h0C, 5'h0C, 5'h0C, 5'h0D, 5'h0D};
  localparam logic       SP [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  localparam logic [3:0] SE [5] = '{4'h5, 4'h4, 4'h5, 4'h3, 4'h4};

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    track_in = 5'h16;
    led_range_err = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    check("idle out", 32'(dout), 32'h1);
    check("fault", 32'({fault_n, fault_oe, iddq}), 32'h4);
    xfer(1'b0, CAS_OFS_CTRL, '0, rd);
    check("ctrl", rd, 32'(CAS_CTRL_RST));
    xfer(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
    xfer(1'b0, 8'h0C, '0, rd);
    check("unmapped", rd, 32'h0);
    xfer(1'b0, CAS_OFS_MONO, '0, rd);
    check("mono", rd, 32'h0);
    $display("test reset done");
    // internal monoflop period with nothing programmed
    master.frame(12, 16'h0, pre, bits);
    repeat (2000) @(posedge ref_clk);
    xfer(1'b0, CAS_OFS_STATUS, '0, rd);
    check("mf early", 32'(rd[1]), 32'h0);
    repeat (150) @(posedge ref_clk);
    xfer(1'b0, CAS_OFS_STATUS, '0, rd);
    check("mf expired", 32'(rd[1]), 32'h1);
    xfer(1'b1, CAS_OFS_MONO, 32'd20, rd);
    $display("test monoflop default done");
    // unsynced gray in all invert settings, binary with neither invert
    for (int i = 0; i < 8; i++) begin
      led_range_err <= UE[i];
      run(UC[i], UT[i], 16'h59A6);
      check("unsync", 32'(bits), 32'(exp_uns(UC[i], UT[i], UE[i], 16'h59A6)));
      check("fault pin", 32'({fault_n, fault_oe}), UE[i] ? 32'h1 : 32'h2);
    end
    led_range_err <= 1'b0;
    xfer(1'b0, CAS_OFS_CTRL, '0, rd);
    check("ctrl back", rd, 32'h5E);
    $display("test unsynced done");
    // short gap must not recapture, a long one must
    run(8'h4F, 5'h1F, 16'h0);
    master.frame(12, 16'h0, pre, bits);
    check("no recapture", 32'(bits[4:0]), 32'h0);
    repeat (40) @(posedge ref_clk);
    master.frame(12, 16'h0, pre, bits);
    check("recapture", 32'(bits[4:0]), 32'h1F);
    $display("test retrigger done");
    // synced modes, trail and lead correction
    for (int i = 0; i < 5; i++) begin
      run(SC[i], ST[i], SP[i] ? 16'h0003 : 16'h0);
      check("sync word", 32'({bits[0], bits[1], bits[2], bits[3]}), 32'(SE[i]));
      check("first low", 32'(pre), SC[i][0] ? 32'(SE[i][3]) : 32'h1);
    end
    $display("test synced done");
    // digital test register replaces the tracks, frozen in binary mode
    run(8'h6F, 5'h00, 16'hFFFF);
    run(8'h6F, 5'h00, 16'hFFFF);
    check("test reg", 32'(bits[4:0]), 32'h1F);
    // a second binary burst shows the register did not take the zeros
    run(8'h6E, 5'h00, 16'h0);
    run(8'h6E, 5'h00, 16'h0);
    check("test frozen", 32'(bits[4:0]), 32'h15);
    xfer(1'b1, CAS_OFS_CTRL, 32'hFF, rd);
    repeat (4) @(posedge ref_clk);
    check("tp oe", 32'(fault_oe), 32'h1);
    check("tp xor", 32'(fault_n), 32'h0);
    $display("test digital done");
    // analog test: all tracks selected, xor on the output
    run(8'h3F, 5'h16, 16'hFFFF);
    check("xor odd", 32'(bits[11]), 32'h1);
    run(8'h3F, 5'h17, 16'hFFFF);
    check("xor even", 32'(bits[11]), 32'h0);
    check("iddq off", 32'(iddq), 32'h0);
    xfer(1'b1, CAS_OFS_CTRL, 32'h3B, rd);
    repeat (4) @(posedge ref_clk);
    check("iddq on", 32'(iddq), 32'h1);
    $display("test analog done");
    report_and_stop;
  end
endmodule
